// ### core/csp_regs.svh
// register map, field positions, reset values and counts of the serial port
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// byte offsets on the register bus
`define CSP_MODE_OFS    8'h00
`define CSP_CTRL0_OFS   8'h04
`define CSP_CTRL1_OFS   8'h08
`define CSP_TXBUF_OFS   8'h0C
`define CSP_RXBUF_OFS   8'h10
`define CSP_RATE_OFS    8'h14
`define CSP_PINSEL_OFS  8'h18
`define CSP_IRQ_OFS     8'h1C
// mode register fields
`define CSP_MODE_SYNC   3'h1
`define CSP_M_EXTCLK    3
`define CSP_M_RSVD      7
// control register 0 fields
`define CSP_C0_ROLE     2
`define CSP_C0_IDLE     3
`define CSP_C0_HSOFF    4
`define CSP_C0_ORDER    7
// control register 1 fields
`define CSP_C1_TXEN     0
`define CSP_C1_TBE      1
`define CSP_C1_RXEN     2
`define CSP_C1_RXF      3
`define CSP_C1_OVR      4
// pin select and request fields
`define CSP_PS_P8DIR    2
`define CSP_IRQ_TX      0
`define CSP_IRQ_RX      1
// software writable bits
`define CSP_C0_WMASK    8'h97
`define CSP_C1_WMASK    8'h05
`define CSP_PS_WMASK    8'h07
// reset values
`define CSP_MODE_RST    8'h00
`define CSP_CTRL0_RST   8'h08
`define CSP_CTRL1_RST   8'h02
`define CSP_RATE_RST    8'h00
`define CSP_PINSEL_RST  8'h00
`define CSP_IRQ_RST     8'h00
// counts: last bit index of a frame, base clock prescale masks
`define CSP_FRAME_LAST  4'h7
`define CSP_PRE_MASK0   8'h00
`define CSP_PRE_MASK1   8'h07
`define CSP_PRE_MASK2   8'h1F
`define CSP_PRE_MASK3   8'hFF
// bus answers
`define CSP_RESP_OKAY   2'h0
`define CSP_RESP_SLVERR 2'h2
`endif

// ### core/csp_pkg.sv
// types shared by the clock synchronous serial port
package csp_pkg;
  // transmitter sequence
  typedef enum logic [1:0] {
    CSP_IDLE  = 2'b00,
    CSP_ARMED = 2'b01,
    CSP_SHIFT = 2'b10
  } csp_tx_st_t;
  // register bus, master to slave
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } csp_axi_req_t;
  // register bus, slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } csp_axi_rsp_t;
  // pin levels seen by the port
  typedef struct packed {
    logic shift_clock_pin;
    logic serial_data_in;
    logic clear_to_send_in;
  } csp_pin_in_t;
  // pin drives, enables active low
  typedef struct packed {
    logic shift_clock_pin;
    logic shift_clock_pin_oe_n;
    logic serial_data_out;
    logic alt_clock_pin_a;
    logic alt_clock_pin_a_oe_n;
    logic hs_pin;
    logic hs_pin_oe_n;
  } csp_pin_out_t;
  // whole state of the port
  typedef struct packed {
    csp_axi_rsp_t rsp;
    csp_pin_out_t pins;
    csp_tx_st_t   st;
    logic [7:0]   mode;
    logic [7:0]   c0;
    logic [7:0]   c1;
    logic [7:0]   rate;
    logic [7:0]   pinsel;
    logic [7:0]   irq;
    logic [7:0]   txbuf;
    logic [7:0]   txsh;
    logic [7:0]   rxsh;
    logic [7:0]   rxbuf;
    logic [3:0]   bitcnt;
    logic [3:0]   rxcnt;
    logic [7:0]   pre;
    logic [7:0]   rcnt;
    logic         sclk_int;
    logic         sy1;
    logic         sy2;
    logic         sy3;
    logic         idle_d;
    logic         tbe_d;
    logic         rxf_d;
    logic [7:0]   aw_addr;
    logic         aw_got;
    logic [7:0]   wbyte;
    logic         wstrb0;
    logic         w_got;
  } csp_state_t;
endpackage

// ### core/csp_port.sv
// clock synchronous serial port with its register slave
//
// How it works
// - mode 001, bit 7 zero selects sync mode
// - mode bit 3: internal or external shift clock
// - base clock divided by n+1, then two
// - control 0 bit 2: clear-to-send or ready-to-receive
// - control 0 bit 4 set: handshake pin unused
// - start needs enable, full buffer, clear-to-send low
// - bits leave on falling clock, LSB first
// - buffer write clears empty; load sets it
// - role bit set ignores clear-to-send at start
// - running frame ignores flag and pin changes
// - start checked only while frame end high
// - idle status sets after frame end, clears on start
// - empty flag rising sets transmit request
// - clock pin choice kept still during frames
// - select bits route clock to three pins
// - held-high data pin needs direction bit
// - receive enable flag turns receiver on
// - ready-to-receive low after enable and dummy write
// - sample on rising clock, eight bits fill buffer
// - new frame over full buffer sets overrun
// - read or disable clears full; overrun on disable
// - bit order swaps wiring at the buffers
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"

module csp_port
  import csp_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // register bus slave
  input  wire csp_axi_req_t axi_i,
  output var  csp_axi_rsp_t axi_o,
  // serial pins
  input  wire csp_pin_in_t  pin_i,
  output var  csp_pin_out_t pin_o
);

  csp_state_t r;               // registered state
  csp_state_t n;               // next state

  logic       serial_on;       // port in clock synchronous mode
  logic       ext_clk;         // shift clock comes from the pin
  logic       int_clk;         // this port makes the shift clock
  logic [7:0] pre_mask;        // prescale mask of the base clock
  logic       tick;            // base clock event
  logic       half;            // half period of the shift clock
  logic       fall_ev;         // shift clock high to low
  logic       rise_ev;         // shift clock low to high
  logic       frame_end_sig;   // no frame in progress
  logic       cts_ok;          // clear-to-send allows a start
  logic       start;           // load buffer into shifter now
  logic       rx_on;           // receiver running
  logic       rts_ready;       // receiver ready for a frame
  logic [1:0] clk_pin_sel;     // clock output pin choice
  logic [7:0] wbyte_ord;       // written byte in wire order
  logic [7:0] rxbuf_ord;       // received byte in read order

  // outputs come straight from the state flops
  assign axi_o = r.rsp;
  assign pin_o = r.pins;

  // mode decode
  assign serial_on = (r.mode[2:0] == `CSP_MODE_SYNC) && !r.mode[`CSP_M_RSVD];
  assign ext_clk   = r.mode[`CSP_M_EXTCLK];
  assign int_clk   = serial_on && !ext_clk;

  // base clock choice; an external clock ignores it
  always_comb begin
    case (r.c0[1:0])
      2'b00:   pre_mask = `CSP_PRE_MASK0;
      2'b01:   pre_mask = `CSP_PRE_MASK1;
      2'b10:   pre_mask = `CSP_PRE_MASK2;
      default: pre_mask = `CSP_PRE_MASK3;
    endcase
  end

  // divide by n+1; each half event toggles the clock, dividing by two
  assign tick = (r.pre & pre_mask) == 8'h00;
  assign half = tick && (r.rcnt == r.rate);

  // edge sources: own divider or the synchronised pin
  assign fall_ev = ext_clk ? (r.sy3 && !r.sy2)
                           : ((r.st == CSP_SHIFT) && half && r.sclk_int);
  assign rise_ev = ext_clk ? (!r.sy3 && r.sy2)
                           : ((r.st == CSP_SHIFT) && half && !r.sclk_int);

  // start condition, tested only between frames
  assign frame_end_sig = (r.st == CSP_IDLE);
  assign cts_ok = r.c0[`CSP_C0_HSOFF] || r.c0[`CSP_C0_ROLE]
                  || !pin_i.clear_to_send_in;
  assign start  = serial_on && frame_end_sig
                  && r.c1[`CSP_C1_TXEN] && !r.c1[`CSP_C1_TBE] && cts_ok;

  // receiver state
  assign rx_on     = serial_on && r.c1[`CSP_C1_RXEN];
  assign rts_ready = rx_on && ((r.st == CSP_ARMED)
                     || (frame_end_sig && !r.c1[`CSP_C1_TBE]));
  assign clk_pin_sel = r.pinsel[1:0];

  // bit order: wiring reversed between bus and buffers
  for (genvar g = 0; g < 8; g++) begin : g_order
    assign wbyte_ord[g] = r.c0[`CSP_C0_ORDER] ? r.wbyte[7-g] : r.wbyte[g];
    assign rxbuf_ord[g] = r.c0[`CSP_C0_ORDER] ? r.rxbuf[7-g] : r.rxbuf[g];
  end

  // next state
  always_comb begin
    n = r;
    // two flops catch the pin, the third marks edges
    n.sy1 = pin_i.shift_clock_pin;
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.pre = r.pre + 8'h01;
    n.idle_d = frame_end_sig;
    n.tbe_d  = r.c1[`CSP_C1_TBE];
    n.rxf_d  = r.c1[`CSP_C1_RXF];

    // rate divider runs on base clock events
    if (tick) begin
      n.rcnt = (r.rcnt == r.rate) ? 8'h00 : r.rcnt + 8'h01;
    end

    // ---- transmitter ----
    if (start) begin
      // buffer moves into the shifter, flags and clock restart
      n.txsh = r.txbuf;
      n.c1[`CSP_C1_TBE] = 1'b1;
      n.c0[`CSP_C0_IDLE] = 1'b0;
      n.bitcnt = 4'h0;
      n.rcnt = 8'h00;
      n.sclk_int = 1'b1;
      // external clock waits for the far side's first fall
      n.st = ext_clk ? CSP_ARMED : CSP_SHIFT;
    end else if (frame_end_sig && !r.idle_d) begin
      // idle status follows frame end by one cycle
      n.c0[`CSP_C0_IDLE] = 1'b1;
    end

    // running frame looks at neither flags nor clear-to-send
    if (!frame_end_sig && serial_on) begin
      if (r.st == CSP_SHIFT && !ext_clk && half) begin
        n.sclk_int = !r.sclk_int;
      end
      if (fall_ev) begin
        // next bit out on the falling edge, low bit first
        n.pins.serial_data_out = r.txsh[0];
        n.txsh = {1'b1, r.txsh[7:1]};
        n.st = CSP_SHIFT;
      end
      if (rise_ev && r.st == CSP_SHIFT) begin
        // eighth rising edge ends the frame
        if (r.bitcnt == `CSP_FRAME_LAST) begin
          n.st = CSP_IDLE;
          n.bitcnt = 4'h0;
        end else begin
          n.bitcnt = r.bitcnt + 4'h1;
        end
      end
    end else if (!serial_on) begin
      // parallel port: frame dropped, line idles high
      n.st = CSP_IDLE;
      n.sclk_int = 1'b1;
      n.pins.serial_data_out = 1'b1;
    end

    // ---- register bus, write side ----
    if (axi_i.awvalid && r.rsp.awready) begin
      n.aw_addr = axi_i.awaddr;
      n.aw_got = 1'b1;
    end
    if (axi_i.wvalid && r.rsp.wready) begin
      n.wbyte = axi_i.wdata[7:0];
      n.wstrb0 = axi_i.wstrb[0];
      n.w_got = 1'b1;
    end
    if (r.rsp.bvalid && axi_i.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    // both halves held and last answer gone: perform the write
    if (r.aw_got && r.w_got && !r.rsp.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = `CSP_RESP_OKAY;
      case ({r.aw_addr[7:2], 2'b00})
        `CSP_MODE_OFS: begin
          if (r.wstrb0) n.mode = r.wbyte;
        end
        `CSP_CTRL0_OFS: begin
          // idle status bit is read only
          if (r.wstrb0) n.c0 = (r.c0 & ~`CSP_C0_WMASK) | (r.wbyte & `CSP_C0_WMASK);
        end
        `CSP_CTRL1_OFS: begin
          // only the two enables are writable
          if (r.wstrb0) n.c1 = (n.c1 & ~`CSP_C1_WMASK) | (r.wbyte & `CSP_C1_WMASK);
        end
        `CSP_TXBUF_OFS: begin
          if (r.wstrb0) begin
            n.txbuf = wbyte_ord;
            n.c1[`CSP_C1_TBE] = 1'b0;
          end
        end
        `CSP_RATE_OFS: begin
          if (r.wstrb0) n.rate = r.wbyte;
        end
        `CSP_PINSEL_OFS: begin
          if (r.wstrb0) n.pinsel = r.wbyte & `CSP_PS_WMASK;
        end
        `CSP_IRQ_OFS: begin
          // write one to clear a request
          if (r.wstrb0) n.irq = r.irq & ~r.wbyte;
        end
        `CSP_RXBUF_OFS: begin
          // receive buffer ignores writes
          n.rsp.bresp = `CSP_RESP_OKAY;
        end
        default: begin
          n.rsp.bresp = `CSP_RESP_SLVERR;
        end
      endcase
    end
    n.rsp.awready = !n.aw_got;
    n.rsp.wready  = !n.w_got;

    // ---- register bus, read side ----
    if (r.rsp.rvalid && axi_i.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_i.arvalid && r.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = `CSP_RESP_OKAY;
      n.rsp.rdata = 32'h0000_0000;
      case ({axi_i.araddr[7:2], 2'b00})
        `CSP_MODE_OFS:   n.rsp.rdata[7:0] = r.mode;
        `CSP_CTRL0_OFS:  n.rsp.rdata[7:0] = r.c0;
        `CSP_CTRL1_OFS:  n.rsp.rdata[7:0] = r.c1;
        `CSP_TXBUF_OFS:  n.rsp.rdata[7:0] = r.txbuf;
        `CSP_RXBUF_OFS: begin
          n.rsp.rdata[7:0] = rxbuf_ord;
          n.c1[`CSP_C1_RXF] = 1'b0;
        end
        `CSP_RATE_OFS:   n.rsp.rdata[7:0] = r.rate;
        `CSP_PINSEL_OFS: n.rsp.rdata[7:0] = r.pinsel;
        `CSP_IRQ_OFS:    n.rsp.rdata[7:0] = r.irq;
        default:         n.rsp.rresp = `CSP_RESP_SLVERR;
      endcase
    end
    n.rsp.arready = !n.rsp.rvalid;

    // ---- receiver ----
    if (!(serial_on && n.c1[`CSP_C1_RXEN])) begin
      // disabled or parallel: flags and bit count cleared
      n.c1[`CSP_C1_RXF] = 1'b0;
      n.c1[`CSP_C1_OVR] = 1'b0;
      n.rxcnt = 4'h0;
    end else if (rise_ev && rx_on) begin
      // sample on the rising edge, low bit arrives first
      n.rxsh = {pin_i.serial_data_in, r.rxsh[7:1]};
      if (r.rxcnt == `CSP_FRAME_LAST) begin
        n.rxbuf = {pin_i.serial_data_in, r.rxsh[7:1]};
        n.rxcnt = 4'h0;
        if (r.c1[`CSP_C1_RXF]) n.c1[`CSP_C1_OVR] = 1'b1;
        n.c1[`CSP_C1_RXF] = 1'b1;
      end else begin
        n.rxcnt = r.rxcnt + 4'h1;
      end
    end

    // requests: a set in the same cycle beats the clear
    if (r.c1[`CSP_C1_TBE] && !r.tbe_d) n.irq[`CSP_IRQ_TX] = 1'b1;
    if (r.c1[`CSP_C1_RXF] && !r.rxf_d) n.irq[`CSP_IRQ_RX] = 1'b1;

    // ---- pins ----
    // clock pin driven only by the clock sender; alt pins apply
    // live, software leaves the choice alone during a frame
    // pins follow the next clock level so data and the pin fall together
    n.pins.shift_clock_pin      = clk_pin_sel[1] ? 1'b1 : n.sclk_int;
    n.pins.shift_clock_pin_oe_n = !int_clk;
    // receive data pin: clock, held high, or input
    n.pins.alt_clock_pin_a      = 1'b1;
    n.pins.alt_clock_pin_a_oe_n = 1'b1;
    if (int_clk) begin
      case (clk_pin_sel)
        2'b10: begin
          n.pins.alt_clock_pin_a      = n.sclk_int;
          n.pins.alt_clock_pin_a_oe_n = 1'b0;
        end
        2'b01, 2'b11: begin
          // held high only when the direction bit says output
          n.pins.alt_clock_pin_a_oe_n = !r.pinsel[`CSP_PS_P8DIR];
        end
        default: begin
          n.pins.alt_clock_pin_a_oe_n = 1'b1;
        end
      endcase
    end
    // handshake pin: third clock, ready-to-receive, or released
    n.pins.hs_pin      = 1'b1;
    n.pins.hs_pin_oe_n = 1'b1;
    if (int_clk && clk_pin_sel == 2'b11) begin
      n.pins.hs_pin      = n.sclk_int;
      n.pins.hs_pin_oe_n = 1'b0;
    end else if (int_clk && clk_pin_sel != 2'b00) begin
      n.pins.hs_pin_oe_n = 1'b1; // plain port pin
    end else if (serial_on && !r.c0[`CSP_C0_HSOFF] && r.c0[`CSP_C0_ROLE]) begin
      n.pins.hs_pin      = !rts_ready;
      n.pins.hs_pin_oe_n = 1'b0;
    end
  end

  // state register, constants only under reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.st <= CSP_IDLE;
      r.mode <= `CSP_MODE_RST;
      r.c0 <= `CSP_CTRL0_RST;
      r.c1 <= `CSP_CTRL1_RST;
      r.rate <= `CSP_RATE_RST;
      r.pinsel <= `CSP_PINSEL_RST;
      r.irq <= `CSP_IRQ_RST;
      r.rsp.awready <= 1'b1;
      r.rsp.wready <= 1'b1;
      r.rsp.arready <= 1'b1;
      r.pins <= '1;
      r.sclk_int <= 1'b1;
      r.sy1 <= 1'b1;
      r.sy2 <= 1'b1;
      r.sy3 <= 1'b1;
      r.idle_d <= 1'b1;
      r.tbe_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_load_sets_empty: assert property (
    $fell(r.st == CSP_IDLE) |-> r.c1[`CSP_C1_TBE] && !r.c0[`CSP_C0_IDLE])
    else $error("empty flag not set at load");

  a_idle_after_end: assert property (
    $rose(r.st == CSP_IDLE) && !start |=> r.c0[`CSP_C0_IDLE])
    else $error("idle status late after frame end");

  a_start_needs_cts: assert property (
    $fell(r.st == CSP_IDLE) && !$past(r.c0[`CSP_C0_HSOFF])
    && !$past(r.c0[`CSP_C0_ROLE]) |-> !$past(pin_i.clear_to_send_in))
    else $error("frame started while clear-to-send high");

  a_tx_lsb_out: assert property (
    fall_ev && r.st != CSP_IDLE && serial_on
    |=> r.pins.serial_data_out == $past(r.txsh[0]))
    else $error("wrong bit on falling clock");

  a_rx_full_set: assert property (
    rise_ev && rx_on && r.rxcnt == `CSP_FRAME_LAST && r.c1[`CSP_C1_RXEN]
    |=> r.c1[`CSP_C1_RXF] || !r.c1[`CSP_C1_RXEN])
    else $error("receive full not set after eight bits");

  a_overrun_set: assert property (
    rise_ev && rx_on && r.rxcnt == `CSP_FRAME_LAST && r.c1[`CSP_C1_RXF]
    && r.c1[`CSP_C1_RXEN] ##1 r.c1[`CSP_C1_RXEN] |-> r.c1[`CSP_C1_OVR])
    else $error("overrun missed");

  a_rxen_clears: assert property (
    !r.c1[`CSP_C1_RXEN] |-> !r.c1[`CSP_C1_RXF] && !r.c1[`CSP_C1_OVR])
    else $error("receive flags held while disabled");

  a_rts_idle_high: assert property (
    serial_on && r.c0[`CSP_C0_ROLE] && !r.c0[`CSP_C0_HSOFF]
    && clk_pin_sel == 2'b00 && !r.c1[`CSP_C1_RXEN]
    |=> r.pins.hs_pin && !r.pins.hs_pin_oe_n)
    else $error("ready-to-receive low while disabled");

  a_clk_on_rxd: assert property (
    int_clk && clk_pin_sel == 2'b10
    |=> !r.pins.alt_clock_pin_a_oe_n && r.pins.shift_clock_pin
        && r.pins.alt_clock_pin_a == r.sclk_int)
    else $error("clock not routed to data pin");

  a_tx_irq_set: assert property (
    $rose(r.c1[`CSP_C1_TBE]) |=> r.irq[`CSP_IRQ_TX])
    else $error("transmit request not raised");

  a_frame_holds: assert property (
    r.st == CSP_SHIFT && serial_on && !rise_ev |=> r.st == CSP_SHIFT)
    else $error("frame cut short");

endmodule // csp_port
`default_nettype wire

// ### test/csp_peer.sv
// far side model: a clock-receiving serial port that swaps one byte per frame
`timescale 1ns/1ns
`default_nettype none

module csp_peer (
  // reset and serial pins
  input  wire logic       rst_n_i,
  input  wire logic       sclk_i,
  input  wire logic       din_i,
  output var  logic       dout_o,
  // byte to send, last byte taken, frames taken
  input  wire logic [7:0] send_i,
  output var  logic [7:0] got_o,
  output var  logic [7:0] cnt_o
);
  logic [7:0] sh;  // receive shifter
  logic [2:0] nb;  // bits taken so far in this frame

  // sample on rising clock, drive on falling clock, scramble the line when idle
  always @(posedge sclk_i or negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_o <= 1'b0;
      nb     <= 3'h0;
      sh     <= 8'h00;
      got_o  <= 8'h00;
      cnt_o  <= 8'h00;
    end else if (sclk_i) begin
      // lsb arrives first
      sh <= {din_i, sh[7:1]};
      nb <= nb + 3'h1;
      if (nb == 3'h7) begin
        // frame over: line no longer holds the last bit
        got_o  <= {din_i, sh[7:1]};
        cnt_o  <= cnt_o + 8'h01;
        dout_o <= ~dout_o;
      end
    end else begin
      // next bit settles before the rising sample
      dout_o <= send_i[nb];
    end
  end
endmodule // csp_peer

`default_nettype wire

// ### test/tb_csp_port.sv
// self-checking bench of the serial port against a far side model
`timescale 1ns/1ns
`default_nettype none
`include "csp_regs.svh"

module tb_csp_port
  import csp_pkg::*;
;
  logic         clk;          // core clock
  logic         rst_n;        // reset, active low
  csp_axi_req_t axi_q;        // bus requests
  csp_axi_rsp_t axi_s;        // bus answers
  csp_pin_in_t  pin_in;       // pin levels into the port
  csp_pin_out_t pin_out;      // pin drives of the port
  logic         cts;          // clear-to-send level, low allows a start
  logic         rxd;          // data from the peer
  wire          sclk_w;       // shift clock wire with pull-up
  logic [7:0]   p_send;       // peer byte to send
  logic [7:0]   p_got;        // peer byte taken
  logic [7:0]   p_cnt;        // peer frame count
  logic [34:0]  note_q[$];    // expected answers, top bit set when compared
  logic [31:0]  seed;         // xorshift state
  int           bad_count;    // mismatches
  int           check_count;  // comparisons

  // released clock pin floats high
  assign sclk_w = pin_out.shift_clock_pin_oe_n ? 1'b1 : pin_out.shift_clock_pin;
  assign pin_in = {sclk_w, rxd, cts};

  csp_port i_csp_port (.core_clk_i(clk), .rst_n_i(rst_n), .axi_i(axi_q), .axi_o(axi_s),
                       .pin_i(pin_in), .pin_o(pin_out));
  csp_peer i_csp_peer (.rst_n_i(rst_n), .sclk_i(sclk_w), .din_i(pin_out.serial_data_out),
                       .dout_o(rxd), .send_i(p_send), .got_o(p_got), .cnt_o(p_cnt));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    give_verdict();
  endtask

  // bus write of one byte, expected response noted
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    logic aw, w, b;
    @(posedge clk);
    note_q.push_back({1'b1, r, 32'h0000_0000});
    {aw, w, b} = 3'b111;
    axi_q.awaddr  <= a;
    axi_q.wdata   <= {24'h00_0000, d};
    axi_q.wstrb   <= 4'h1;
    axi_q.awvalid <= 1'b1;
    axi_q.wvalid  <= 1'b1;
    axi_q.bready  <= 1'b1;
    for (n = 0; n < 200 && (aw || w || b); n++) begin
      @(posedge clk);
      if (aw && axi_s.awready) begin
        aw = 1'b0;
        axi_q.awvalid <= 1'b0;
      end
      if (w && axi_s.wready) begin
        w = 1'b0;
        axi_q.wvalid <= 1'b0;
      end
      if (b && axi_s.bvalid) begin
        b = 1'b0;
        axi_q.bready <= 1'b0;
      end
    end
    if (n == 200) hang();
  endtask

  // bus read, expected {rresp, rdata} noted
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic ar, rr;
    @(posedge clk);
    note_q.push_back({1'b1, e});
    {ar, rr} = 2'b11;
    axi_q.araddr  <= a;
    axi_q.arvalid <= 1'b1;
    axi_q.rready  <= 1'b1;
    for (n = 0; n < 200 && (ar || rr); n++) begin
      @(posedge clk);
      if (ar && axi_s.arready) begin
        ar = 1'b0;
        axi_q.arvalid <= 1'b0;
      end
      if (rr && axi_s.rvalid) begin
        rr = 1'b0;
        axi_q.rready <= 1'b0;
      end
    end
    if (n == 200) hang();
  endtask

  task automatic take(input logic [33:0] seen);
    logic [34:0] e;
    if (note_q.size() == 0) begin
      hang();
    end else begin
      e = note_q.pop_front();
      if (e[34]) check(seen, e[33:0]);
    end
  endtask

  // answer watcher: oldest note against each response
  always @(posedge clk) begin
    if (axi_q.bready && axi_s.bvalid) take({axi_s.bresp, 32'h0000_0000});
    if (axi_q.rready && axi_s.rvalid) take({axi_s.rresp, axi_s.rdata});
  end

  // main sequence
  initial begin
    logic [7:0] t, pv, old, n, sel;
    logic       ord;
    int         w;
    axi_q = '0;
    cts = 1'b1;
    rst_n = 1'b0;
    p_send = 8'h00;
    seed = 32'h0000_a913;
    bad_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CSP_MODE_OFS, {26'h0, `CSP_MODE_RST});
    rd(`CSP_CTRL0_OFS, {26'h0, `CSP_CTRL0_RST});
    rd(`CSP_CTRL1_OFS, {26'h0, `CSP_CTRL1_RST});
    rd(`CSP_IRQ_OFS, {26'h0, `CSP_IRQ_RST});
    rd(8'h20, {`CSP_RESP_SLVERR, 32'h0000_0000});
    wr(8'h20, 8'h55, `CSP_RESP_SLVERR);
    n = 8'(rnd() % 32'd3);
    sel = 8'(rnd() % 32'd2);
    wr(`CSP_MODE_OFS, 8'h01, `CSP_RESP_OKAY);
    wr(`CSP_RATE_OFS, n, `CSP_RESP_OKAY);
    wr(`CSP_CTRL0_OFS, sel, `CSP_RESP_OKAY);
    wr(`CSP_CTRL1_OFS, 8'h05, `CSP_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      t = 8'(rnd());
      pv = 8'(rnd());
      ord = (i == 3);
      p_send <= pv;
      cts <= (i == 1);
      if (ord) wr(`CSP_CTRL0_OFS, 8'h80 | sel, `CSP_RESP_OKAY);
      old = p_cnt;
      wr(`CSP_TXBUF_OFS, t, `CSP_RESP_OKAY);
      if (i == 1) begin
        repeat (40) @(posedge clk);
        rd(`CSP_CTRL0_OFS, {26'h0, 8'h08 | sel});
        rd(`CSP_CTRL1_OFS, 34'h0_0000_0005);
        cts <= 1'b0;
      end
      if (i == 2) begin
        repeat (12) @(posedge clk);
        cts <= 1'b1;
      end
      for (w = 0; w < 4000 && p_cnt === old; w++) @(posedge clk);
      if (w == 4000) hang();
      repeat (3) @(posedge clk);
      check({26'h0, p_got}, {26'h0, ord ? rev(t) : t});
      if (i == 0) begin
        rd(`CSP_CTRL1_OFS, 34'h0_0000_000F);
        rd(`CSP_IRQ_OFS, 34'h0_0000_0003);
        wr(`CSP_IRQ_OFS, 8'h03, `CSP_RESP_OKAY);
        rd(`CSP_IRQ_OFS, 34'h0_0000_0000);
      end
      if (ord) rd(`CSP_CTRL1_OFS, 34'h0_0000_001F);
      if (i != 2) rd(`CSP_RXBUF_OFS, {26'h0, ord ? rev(pv) : pv});
    end
    rd(`CSP_CTRL1_OFS, 34'h0_0000_0017);
    wr(`CSP_CTRL1_OFS, 8'h01, `CSP_RESP_OKAY);
    rd(`CSP_CTRL1_OFS, 34'h0_0000_0003);
    wr(`CSP_PINSEL_OFS, 8'h05, `CSP_RESP_OKAY); // changed only between frames
    repeat (2) @(posedge clk);
    check({32'h0, pin_out.alt_clock_pin_a_oe_n, pin_out.alt_clock_pin_a}, 34'h1);
    wr(`CSP_PINSEL_OFS, 8'h01, `CSP_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({33'h0, pin_out.alt_clock_pin_a_oe_n}, 34'h1);
    // handshake pin as ready-to-receive output, receiver off
    wr(`CSP_PINSEL_OFS, 8'h00, `CSP_RESP_OKAY);
    wr(`CSP_CTRL0_OFS, 8'h04 | sel, `CSP_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, pin_out.shift_clock_pin_oe_n, pin_out.hs_pin_oe_n, pin_out.hs_pin}, 34'h1);
    // receiver on, transmitter off, dummy write clears empty
    wr(`CSP_CTRL1_OFS, 8'h04, `CSP_RESP_OKAY);
    wr(`CSP_TXBUF_OFS, 8'h00, `CSP_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({32'h0, pin_out.hs_pin_oe_n, pin_out.hs_pin}, 34'h0);
    rd(`CSP_CTRL1_OFS, 34'h0_0000_0004);
    give_verdict();
  end
endmodule // tb_csp_port

`default_nettype wire
